// >>> bax_core.sv
// Execution core for six byte and flow instructions.
// Assumes the decoder holds op inputs for one cycle and memory reads are combinational.
`timescale 1ns/1ps

// Contract
// - Add accumulator and memory operand, update flags
// - Destination bit chooses accumulator or memory
// - Arithmetic shift keeps bit 7, bit0 to carry
// - Add with carry sums three inputs
// - Bit clear zeroes chosen bit, flags untouched
// - Test bit one: next instruction runs normally
// - Test bit zero: next becomes nop, two cycles
// - Branch adds sign-extended nine-bit offset, flags kept
// - Branch target is pc plus one plus offset
// - Branch reach limited to -256 to 255
module bax_core
    import bax_pkg::*;
(
    // Clock and reset.
    input  wire logic                  mclk_i,
    input  wire logic                  sys_rst_i,
    // Decoded instruction.
    input  wire logic                  op_valid_i,
    input  wire bax_pkg::bax_op_t      op_i,
    input  wire logic [6:0]            mem_addr_i,
    input  wire logic                  dest_sel_i,
    input  wire logic [2:0]            bit_sel_i,
    input  wire logic [8:0]            jump_ofs_i,
    // Memory operand and current counter (already incremented).
    input  wire logic [7:0]            mem_rdata_i,
    input  wire logic [14:0]           pc_next_i,
    // Results.
    output logic      [7:0]            accum_o,
    output logic                       mem_we_o,
    output logic      [6:0]            mem_waddr_o,
    output logic      [7:0]            mem_wdata_o,
    output logic                       carry_flag_o,
    output logic                       nibble_carry_flag_o,
    output logic                       zero_flag_o,
    output logic                       pc_load_o,
    output logic      [14:0]           pc_target_o,
    output logic                       flush_next_o,
    output logic                       busy_o
);

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        BAX_ST_RUN  = 2'b01,
        BAX_ST_NOP  = 2'b10
    } bax_state_t;

    bax_state_t state;
    bax_state_t next_state;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic       run_ok;
    wire logic       is_add;
    wire logic       is_addc;
    wire logic       is_asr;
    wire logic       is_bclr;
    wire logic       is_btsz;
    wire logic       is_jrel;
    wire logic       is_arith;
    wire logic       test_bit;
    wire logic       skip_hit;

    // An operation issued during the inserted nop cycle is ignored.
    assign run_ok   = op_valid_i && (state == BAX_ST_RUN);
    assign is_add   = run_ok && (op_i == BAX_OP_ADD);
    assign is_addc  = run_ok && (op_i == BAX_OP_ADDC);
    assign is_asr   = run_ok && (op_i == BAX_OP_ASR);
    assign is_bclr  = run_ok && (op_i == BAX_OP_BCLR);
    assign is_btsz  = run_ok && (op_i == BAX_OP_BTSZ);
    assign is_jrel  = run_ok && (op_i == BAX_OP_JREL);
    assign is_arith = is_add || is_addc || is_asr;
    assign test_bit = mem_rdata_i[bit_sel_i];
    assign skip_hit = is_btsz && !test_bit;

    // ------------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------------
    wire logic [7:0]  add_sum;
    wire logic        add_nib;
    wire logic        add_cy;
    wire logic        add_cin;
    wire logic [7:0]  asr_res;
    wire logic [7:0]  arith_res;
    wire logic [7:0]  clr_mask;
    wire logic [14:0] ofs_ext;
    wire logic [14:0] jump_dst;

    // Carry only enters for the three-input add.
    assign add_cin = is_addc ? carry_flag_o : 1'b0;

    bax_adder u_adder
    (
        .a_i         (accum_o),
        .b_i         (mem_rdata_i),
        .cin_i       (add_cin),
        .sum_o       (add_sum),
        .nib_carry_o (add_nib),
        .carry_o     (add_cy)
    );

    // Shift right with the sign bit held.
    assign asr_res   = {mem_rdata_i[BAX_MSB], mem_rdata_i[7:1]};
    assign arith_res = is_asr ? asr_res : add_sum;
    assign clr_mask  = ~(8'h01 << bit_sel_i);

    // Nine-bit signed offset reaches -256..255 from the advanced counter.
    assign ofs_ext  = {{(BAX_PC_W - BAX_OFS_W){jump_ofs_i[8]}}, jump_ofs_i};
    assign jump_dst = pc_next_i + ofs_ext;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    logic [7:0]  next_accum;
    logic        next_we;
    logic [7:0]  next_wdata;
    logic        next_carry;
    logic        next_nib;
    logic        next_zero;

    // Route arithmetic results and pick flag updates.
    always_comb
    begin
        next_accum = accum_o;
        next_we    = 1'b0;
        next_wdata = 8'h00;
        next_carry = carry_flag_o;
        next_nib   = nibble_carry_flag_o;
        next_zero  = zero_flag_o;
        if (is_arith)
        begin
            if (dest_sel_i == BAX_DEST_MEM)
            begin
                next_we    = 1'b1;
                next_wdata = arith_res;
            end
            else
            begin
                next_accum = arith_res;
            end
            next_zero = (arith_res == 8'h00);
            if (is_asr)
            begin
                next_carry = mem_rdata_i[0];
            end
            else
            begin
                next_carry = add_cy;
                next_nib   = add_nib;
            end
        end
        else if (is_bclr)
        begin
            next_we    = 1'b1;
            next_wdata = mem_rdata_i & clr_mask;
        end
    end

    // Insert one nop cycle after a skip or a taken branch.
    always_comb
    begin
        next_state = state;
        unique case (state)
            BAX_ST_RUN:
            begin
                if (skip_hit || is_jrel)
                begin
                    next_state = BAX_ST_NOP;
                end
            end
            BAX_ST_NOP:
            begin
                next_state = BAX_ST_RUN;
            end
            default:
            begin
                next_state = BAX_ST_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Architectural state and flags.
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            state               <= BAX_ST_RUN;
            accum_o             <= BAX_ACC_RST;
            carry_flag_o        <= 1'b0;
            nibble_carry_flag_o <= 1'b0;
            zero_flag_o         <= 1'b0;
        end
        else
        begin
            state               <= next_state;
            accum_o             <= next_accum;
            carry_flag_o        <= next_carry;
            nibble_carry_flag_o <= next_nib;
            zero_flag_o         <= next_zero;
        end
    end

    // Registered memory write and flow outputs.
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            mem_we_o     <= 1'b0;
            mem_waddr_o  <= 7'h00;
            mem_wdata_o  <= 8'h00;
            pc_load_o    <= 1'b0;
            pc_target_o  <= BAX_PC_RST;
            flush_next_o <= 1'b0;
            busy_o       <= 1'b0;
        end
        else
        begin
            mem_we_o     <= next_we;
            mem_waddr_o  <= mem_addr_i;
            mem_wdata_o  <= next_wdata;
            pc_load_o    <= is_jrel;
            pc_target_o  <= is_jrel ? jump_dst : pc_target_o;
            flush_next_o <= skip_hit || is_jrel;
            busy_o       <= (next_state == BAX_ST_NOP);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_skip_issue;
        op_valid_i && state == BAX_ST_RUN && op_i == BAX_OP_BTSZ
            && !mem_rdata_i[bit_sel_i];
    endsequence

    sequence s_nop_slot;
        flush_next_o && busy_o ##1 !busy_o;
    endsequence

    property p_add_result;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (is_add && !dest_sel_i) |=> accum_o == $past(accum_o) + $past(mem_rdata_i);
    endproperty
    a_add_result: assert property (p_add_result) else $error("add result wrong");

    property p_dest_mem;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (is_arith && dest_sel_i) |=> mem_we_o && accum_o == $past(accum_o);
    endproperty
    a_dest_mem: assert property (p_dest_mem) else $error("memory destination wrong");

    property p_asr;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (is_asr && dest_sel_i) |=> mem_wdata_o[7] == $past(mem_rdata_i[7])
            && mem_wdata_o[6:0] == $past(mem_rdata_i[7:1])
            && carry_flag_o == $past(mem_rdata_i[0]);
    endproperty
    a_asr: assert property (p_asr) else $error("shift result wrong");

    property p_addc;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (is_addc && !dest_sel_i) |=> {carry_flag_o, accum_o} ==
            9'($past(accum_o)) + 9'($past(mem_rdata_i)) + 9'($past(carry_flag_o));
    endproperty
    a_addc: assert property (p_addc) else $error("add with carry wrong");

    property p_bclr;
        @(posedge mclk_i) disable iff (sys_rst_i)
        is_bclr |=> !mem_wdata_o[$past(bit_sel_i)] && $stable(zero_flag_o)
            && $stable(carry_flag_o);
    endproperty
    a_bclr: assert property (p_bclr) else $error("bit clear wrong");

    property p_no_skip;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (is_btsz && test_bit) |=> !flush_next_o && $stable(zero_flag_o);
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("skip taken on set bit");

    property p_skip;
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_skip_issue |=> s_nop_slot;
    endproperty
    a_skip: assert property (p_skip) else $error("skip not two cycles");

    property p_jump;
        @(posedge mclk_i) disable iff (sys_rst_i)
        is_jrel |=> pc_load_o && busy_o && $stable(carry_flag_o)
            && pc_target_o == $past(pc_next_i) + {{6{$past(jump_ofs_i[8])}}, $past(jump_ofs_i)};
    endproperty
    a_jump: assert property (p_jump) else $error("branch target wrong");

    property p_zero;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (is_arith && !dest_sel_i) |=> zero_flag_o == (accum_o == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule

// >>> bax_pkg.sv
// Package for the byte ALU and branch execution block.
// Assumes a single instruction clock and an external decoder that issues operations.
package bax_pkg;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        BAX_OP_NONE  = 3'h0,
        BAX_OP_ADD   = 3'h1,
        BAX_OP_ADDC  = 3'h2,
        BAX_OP_ASR   = 3'h3,
        BAX_OP_BCLR  = 3'h4,
        BAX_OP_BTSZ  = 3'h5,
        BAX_OP_JREL  = 3'h6
    } bax_op_t;

    // ------------------------------------------------------------------
    // Widths, field positions and reset values
    // ------------------------------------------------------------------
    localparam int          BAX_DATA_W     = 8;
    localparam int          BAX_ADDR_W     = 7;
    localparam int          BAX_PC_W       = 15;
    localparam int          BAX_OFS_W      = 9;
    localparam int          BAX_NIB_BIT    = 4;
    localparam int          BAX_MSB        = 7;
    localparam logic [14:0] BAX_PC_RST     = 15'h0000;
    localparam logic [7:0]  BAX_ACC_RST    = 8'h00;
    localparam logic        BAX_DEST_MEM   = 1'b1;
    localparam int          BAX_TWO_CYCLES = 2;

endpackage

// >>> bax_adder.sv
// Eight-bit adder with carry in, carry out of bit 3 and of bit 7.
// Assumes purely combinational use by the execution core.
`timescale 1ns/1ps

module bax_adder
    import bax_pkg::*;
(
    // Operands.
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] b_i,
    input  wire logic       cin_i,
    // Results.
    output logic      [7:0] sum_o,
    output logic            nib_carry_o,
    output logic            carry_o
);

    // ------------------------------------------------------------------
    // Split add
    // ------------------------------------------------------------------
    wire logic [4:0] low_sum;
    wire logic [4:0] high_sum;

    // Low nibble first so its carry is visible as the nibble carry.
    assign low_sum     = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    assign high_sum    = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, low_sum[BAX_NIB_BIT]};
    assign sum_o       = {high_sum[3:0], low_sum[3:0]};
    assign nib_carry_o = low_sum[BAX_NIB_BIT];
    assign carry_o     = high_sum[BAX_NIB_BIT];

endmodule

// >>> tb_top.sv
// Self-checking bench for the byte ALU and branch execution core.
// Assumes bax_pkg and bax_core are compiled first; the bench stands in for the decoder.
`timescale 1ns/1ps

module tb_top;
    import bax_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic          mclk_i = 1'b0;
    logic          sys_rst_i = 1'b1;
    logic          op_valid_i = 1'b0;
    bax_op_t       op_i = BAX_OP_NONE;
    logic [6:0]    mem_addr_i = 7'h00;
    logic          dest_sel_i = 1'b0;
    logic [2:0]    bit_sel_i = 3'h0;
    logic [8:0]    jump_ofs_i = 9'h000;
    logic [7:0]    mem_rdata_i = 8'h00;
    logic [14:0]   pc_next_i = 15'h0000;
    logic [7:0]    accum_o, mem_wdata_o;
    logic [6:0]    mem_waddr_o;
    logic [14:0]   pc_target_o;
    logic          mem_we_o, carry_flag_o, nibble_carry_flag_o, zero_flag_o;
    logic          pc_load_o, flush_next_o, busy_o;
    int            err_total = 0;
    int            check_count = 0;

    // The clock toggles every half period of 25 ns.
    always #25 mclk_i = ~mclk_i;

    bax_core dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid_i),
        .op_i(op_i), .mem_addr_i(mem_addr_i), .dest_sel_i(dest_sel_i),
        .bit_sel_i(bit_sel_i), .jump_ofs_i(jump_ofs_i), .mem_rdata_i(mem_rdata_i),
        .pc_next_i(pc_next_i), .accum_o(accum_o), .mem_we_o(mem_we_o),
        .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o),
        .carry_flag_o(carry_flag_o), .nibble_carry_flag_o(nibble_carry_flag_o),
        .zero_flag_o(zero_flag_o), .pc_load_o(pc_load_o), .pc_target_o(pc_target_o),
        .flush_next_o(flush_next_o), .busy_o(busy_o));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Compares one value with case equality and counts the result.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Presents one operation for one edge; results are settled when it returns.
    task automatic issue(input bax_op_t op, input logic [6:0] a, input logic d,
                         input logic [2:0] b, input logic [8:0] k, input logic [7:0] rd);
        @(posedge mclk_i);
        #1;
        op_valid_i = 1'b1;
        op_i = op;
        mem_addr_i = a;
        dest_sel_i = d;
        bit_sel_i = b;
        jump_ofs_i = k;
        mem_rdata_i = rd;
        @(posedge mclk_i);
        #1;
        op_valid_i = 1'b0;
    endtask

    function automatic logic [15:0] flags();
        return {13'h0, carry_flag_o, nibble_carry_flag_o, zero_flag_o};
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Plain add into the accumulator, then an add that wraps to zero.
    task automatic test_add();
        issue(BAX_OP_ADD, 7'h7f, 1'b0, 3'h0, 9'h000, 8'h8f);
        chk(accum_o, 16'h008f, "add sum");
        chk(flags(), 16'h0000, "add flags clear");
        chk(mem_we_o, 16'h0000, "add dest acc no write");
        issue(BAX_OP_ADD, 7'h00, 1'b0, 3'h0, 9'h000, 8'h71);
        chk(accum_o, 16'h0000, "add wrap");
        chk(flags(), 16'h0007, "add carry nibble zero");
        $display("test add done");
    endtask

    // Add with carry in set and to memory, then with carry in clear.
    task automatic test_addc();
        issue(BAX_OP_ADDC, 7'h15, 1'b1, 3'h0, 9'h000, 8'h0f);
        chk(mem_we_o, 16'h0001, "addc write pulse");
        chk(mem_waddr_o, 16'h0015, "addc address");
        chk(mem_wdata_o, 16'h0010, "addc three input sum");
        chk(accum_o, 16'h0000, "addc acc kept");
        chk(flags(), 16'h0002, "addc nibble carry");
        issue(BAX_OP_ADDC, 7'h01, 1'b0, 3'h0, 9'h000, 8'h05);
        chk(accum_o, 16'h0005, "addc carry clear sum");
        chk(flags(), 16'h0000, "addc flags");
        $display("test addc done");
    endtask

    // Shift keeps the top bit and moves bit 0 into carry.
    task automatic test_asr();
        issue(BAX_OP_ASR, 7'h22, 1'b1, 3'h0, 9'h000, 8'h81);
        chk(mem_wdata_o, 16'h00c0, "asr sign kept");
        chk(mem_we_o, 16'h0001, "asr to memory");
        chk(flags(), 16'h0004, "asr carry");
        issue(BAX_OP_ASR, 7'h22, 1'b0, 3'h0, 9'h000, 8'h01);
        chk(accum_o, 16'h0000, "asr to acc");
        chk(flags(), 16'h0005, "asr carry and zero");
        $display("test asr done");
    endtask

    // Every bit position is cleared in turn; the flags stay as they were.
    task automatic test_bclr();
        for (int b = 0; b < 8; b++)
        begin
            issue(BAX_OP_BCLR, 7'h40, 1'b0, 3'(b), 9'h000, 8'hff);
            chk(mem_wdata_o, {8'h00, 8'hff & ~(8'h01 << b)}, "bclr data");
            chk(mem_we_o, 16'h0001, "bclr write");
            chk(flags(), 16'h0005, "bclr flags kept");
        end
        // The idle code must neither write nor touch the flags.
        issue(BAX_OP_NONE, 7'h40, 1'b1, 3'h0, 9'h000, 8'h00);
        chk(mem_we_o, 16'h0000, "none no write");
        chk(flags(), 16'h0005, "none flags kept");
        chk(pc_load_o, 16'h0000, "none no load");
        $display("test bclr done");
    endtask

    // Bit set runs on; bit clear flushes and ignores the op in the nop cycle.
    task automatic test_btsz();
        issue(BAX_OP_BTSZ, 7'h10, 1'b0, 3'h3, 9'h000, 8'h08);
        chk(flush_next_o, 16'h0000, "btsz set no flush");
        chk(busy_o, 16'h0000, "btsz set one cycle");
        chk(flags(), 16'h0005, "btsz flags kept");
        // Driven by hand so that valid stays high into the nop cycle.
        @(posedge mclk_i);
        #1;
        op_valid_i = 1'b1;
        op_i = BAX_OP_BTSZ;
        mem_rdata_i = 8'hf7;
        @(posedge mclk_i);
        #1;
        chk(flush_next_o, 16'h0001, "btsz clear flush");
        chk(busy_o, 16'h0001, "btsz nop cycle");
        op_i = BAX_OP_ADD;
        dest_sel_i = 1'b1;
        mem_rdata_i = 8'h01;
        @(posedge mclk_i);
        #1;
        op_valid_i = 1'b0;
        chk(mem_we_o, 16'h0000, "op in nop cycle ignored");
        chk(flags(), 16'h0005, "nop cycle flags kept");
        chk(flush_next_o, 16'h0000, "flush one cycle");
        chk(busy_o, 16'h0000, "btsz two cycles only");
        $display("test btsz done");
    endtask

    // Branch to both ends of the reach and across the counter wrap.
    task automatic test_jrel();
        pc_next_i = 15'h0100;
        issue(BAX_OP_JREL, 7'h00, 1'b0, 3'h0, 9'h100, 8'h00);
        chk(pc_load_o, 16'h0001, "jrel load");
        chk(pc_target_o, 16'h0000, "jrel minus 256");
        chk(flush_next_o, 16'h0001, "jrel flush");
        chk(flags(), 16'h0005, "jrel flags kept");
        @(posedge mclk_i);
        #1;
        chk(pc_load_o, 16'h0000, "jrel load pulse ends");
        chk(busy_o, 16'h0000, "jrel two cycles");
        pc_next_i = 15'h0200;
        issue(BAX_OP_JREL, 7'h00, 1'b0, 3'h0, 9'h0ff, 8'h00);
        chk(pc_target_o, 16'h02ff, "jrel plus 255");
        pc_next_i = 15'h0010;
        @(posedge mclk_i);
        issue(BAX_OP_JREL, 7'h00, 1'b0, 3'h0, 9'h1ef, 8'h00);
        chk(pc_target_o, 16'h7fff, "jrel sign extend wrap");
        $display("test jrel done");
    endtask

    // ------------------------------------------------------------------
    // Verdict, main sequence and watchdog
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Reset for four cycles, then run every scenario in order.
    initial
    begin
        repeat (4) @(posedge mclk_i);
        #1;
        sys_rst_i = 1'b0;
        test_add();
        test_addc();
        test_asr();
        test_bclr();
        test_btsz();
        test_jrel();
        give_verdict();
    end

    // The tests need well under 100 cycles; 2000 cycles means a hang.
    initial
    begin
        #(2000 * 50);
        err_total++;
        give_verdict();
    end

endmodule
